// *** test/dacm_cpu_model.sv ***
`timescale 1ns/100ps
module dacm_cpu_model (
   input wire logic aclk,
   output logic bus_valid,
   output dacm_pkg::dacm_addr_t bus_addr,
   output logic bus_rw,
   output logic bus_word,
   output logic [15:0] bus_data,
   output logic exec_valid,
   output dacm_pkg::dacm_addr_t exec_addr
);
   import dacm_pkg::*;
   initial
   begin
      bus_valid = 1'b0;
      bus_addr = 16'h0000;
      bus_rw = 1'b0;
      bus_word = 1'b0;
      bus_data = 16'h0000;
      exec_valid = 1'b0;
      exec_addr = 16'h0000;
   end
   // one bus cycle; idle lines then show the inverse of the last value
   task automatic access(input dacm_addr_t a, input logic rw, input logic w,
      input logic [15:0] d);
      @(posedge aclk);
      bus_valid <= 1'b1;
      bus_addr <= a;
      bus_rw <= rw;
      bus_word <= w;
      bus_data <= d;
      @(posedge aclk);
      bus_valid <= 1'b0;
      bus_addr <= ~a;
      bus_rw <= ~rw;
      bus_word <= ~w;
      bus_data <= ~d;
   endtask
   // instruction reaching execution, one cycle
   task automatic execute(input dacm_addr_t a);
      @(posedge aclk);
      exec_valid <= 1'b1;
      exec_addr <= a;
      @(posedge aclk);
      exec_valid <= 1'b0;
      exec_addr <= ~a;
   endtask
endmodule

// *** test/debug_address_comparator_match_tb.sv ***
`timescale 1ns/100ps
`include "dacm_consts.svh"
module debug_address_comparator_match_tb;
   import dacm_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, trigger, irq;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd_v;
   logic [2:0] match_out;
   logic bus_valid, bus_rw, bus_word, exec_valid;
   dacm_addr_t bus_addr, exec_addr;
   logic [15:0] bus_data;
   int bad_count = 0, tests_run = 0, cycles = 0, trig_cnt = 0, t0;
   int mcnt [3] = '{0, 0, 0};

   always #12.5 aclk = ~aclk;

   dacm_top uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_rw(bus_rw),
      .bus_word(bus_word), .bus_data(bus_data), .exec_valid(exec_valid),
      .exec_addr(exec_addr), .match_out(match_out), .trigger(trigger),
      .irq(irq));

   dacm_cpu_model cpu (.aclk(aclk), .bus_valid(bus_valid),
      .bus_addr(bus_addr), .bus_rw(bus_rw), .bus_word(bus_word),
      .bus_data(bus_data), .exec_valid(exec_valid),
      .exec_addr(exec_addr));

   // event counters and run ceiling
   always @(posedge aclk)
   begin
      cycles++;
      for (int i = 0; i < 3; i++)
         if (match_out[i] === 1'b1) mcnt[i]++;
      if (trigger === 1'b1) trig_cnt++;
      if (cycles == 20000)
      begin
         bad_count++;
         print_verdict();
      end
   end

   task print_verdict;
      if (bad_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s,
      input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd_v = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axi_wr(a, d, 4'hf);
      chk("bresp", rsp, `DACM_RESP_OKAY);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      axi_rd(a);
      chk("rdata", rd_v, e);
      chk("rresp", rsp, `DACM_RESP_OKAY);
   endtask

   // one bus access or execution, then match counts per channel
   task automatic ev(input logic x, input dacm_addr_t a, input logic rw,
      input logic w, input logic [15:0] d, input logic [2:0] e);
      int b [3];
      for (int i = 0; i < 3; i++) b[i] = mcnt[i];
      if (x) cpu.execute(a);
      else cpu.access(a, rw, w, d);
      repeat (4) @(posedge aclk);
      for (int i = 0; i < 3; i++) chk("match", 32'(mcnt[i] - b[i]), e[i]);
   endtask

   task t_reset;
      rd(`DACM_CTRL, 32'h0);
      rd(`DACM_STATE, 32'h0);
      rd(`DACM_STATUS, 32'h0);
      axi_rd(8'h40);
      chk("rresp", rsp, `DACM_RESP_SLVERR);
      chk("rdata", rd_v, 32'h0);
      axi_wr(8'h41, 32'h1, 4'hf);
      chk("bresp", rsp, `DACM_RESP_SLVERR);
      axi_wr(`DACM_CTRL, 32'h3, 4'h0);
      rd(`DACM_CTRL, 32'h0);
   endtask

   task t_exact;
      wr(`DACM_CMP_ADDR0, 32'h1234);
      wr(`DACM_CMP_ADDR0 + 8'h04, 32'h2000);
      wr(`DACM_CMP_ADDR0 + 8'h08, 32'h3001);
      rd(`DACM_CMP_ADDR0 + 8'h08, 32'h3001);
      ev(0, 16'h1234, 1, 0, 16'h0, 3'b001);
      ev(0, 16'h1234, 0, 0, 16'h0, 3'b001);
      ev(0, 16'h1235, 1, 0, 16'h0, 3'b000);
      ev(0, 16'h2000, 1, 1, 16'h0, 3'b010);
      ev(0, 16'h3001, 0, 0, 16'h0, 3'b100);
      wr(`DACM_CMP_CTL0, 32'h06);
      ev(0, 16'h1234, 1, 0, 16'h0, 3'b001);
      ev(0, 16'h1234, 0, 0, 16'h0, 3'b000);
      wr(`DACM_CMP_CTL0, 32'h02);
      ev(0, 16'h1234, 0, 0, 16'h0, 3'b001);
      ev(0, 16'h1234, 1, 0, 16'h0, 3'b000);
      wr(`DACM_CMP_CTL0, 32'h00);
   endtask

   task t_size;
      wr(`DACM_CMP_CTL0 + 8'h04, 32'h08);
      ev(0, 16'h2000, 1, 0, 16'h0, 3'b010);
      ev(0, 16'h2000, 1, 1, 16'h0, 3'b000);
      wr(`DACM_CMP_CTL0 + 8'h04, 32'h18);
      ev(0, 16'h2000, 0, 1, 16'h0, 3'b010);
      ev(0, 16'h2000, 0, 0, 16'h0, 3'b000);
      wr(`DACM_CMP_CTL0 + 8'h04, 32'h00);
      wr(`DACM_CMP_CTL0 + 8'h08, 32'h18);
      ev(0, 16'h3001, 1, 0, 16'h0, 3'b100);
      ev(0, 16'h3000, 1, 1, 16'h0, 3'b000);
      wr(`DACM_CMP_CTL0 + 8'h08, 32'h00);
   endtask

   task t_tag;
      wr(`DACM_CMP_ADDR0, 32'h4000);
      wr(`DACM_CMP_CTL0, 32'h03);
      ev(0, 16'h4000, 0, 0, 16'h0, 3'b000);
      ev(1, 16'h4000, 0, 0, 16'h0, 3'b001);
      wr(`DACM_CMP_ADDR0, 32'h4100);
      wr(`DACM_CMP_CTL0, 32'h00);
      ev(0, 16'h4100, 1, 1, 16'h0, 3'b001);
   endtask

   task t_data;
      wr(`DACM_CMP_ADDR0, 32'h5000);
      wr(`DACM_CMP_DATA0, 32'h0055);
      wr(`DACM_CMP_CTL0, 32'h20);
      ev(0, 16'h5000, 0, 0, 16'h0011, 3'b000);
      ev(0, 16'h5000, 0, 0, 16'h0055, 3'b001);
      ev(0, 16'h5000, 0, 0, 16'h0011, 3'b001);
      wr(`DACM_CMP_CTL0, 32'h00);
   endtask

   task t_range;
      wr(`DACM_CMP_ADDR0, 32'h6000);
      wr(`DACM_CMP_ADDR0 + 8'h04, 32'h60ff);
      wr(`DACM_CTRL, 32'h2);
      ev(0, 16'h6080, 1, 0, 16'h0, 3'b001);
      ev(0, 16'h6081, 1, 0, 16'h0, 3'b000);
      ev(0, 16'h60ff, 1, 0, 16'h0, 3'b000);
      ev(0, 16'h3001, 1, 0, 16'h0, 3'b100);
      ev(0, 16'h6000, 1, 0, 16'h0, 3'b001);
      wr(`DACM_CTRL, 32'h0);
   endtask

   task t_seq;
      wr(`DACM_CMP_ADDR0, 32'h1234);
      wr(`DACM_CMP_ADDR0 + 8'h04, 32'h2000);
      wr(`DACM_SEQ, 32'he4);
      wr(`DACM_MASK, 32'h08);
      axi_rd(`DACM_STATUS);
      wr(`DACM_CTRL, 32'h1);
      t0 = trig_cnt;
      ev(0, 16'h3001, 1, 0, 16'h0, 3'b100);
      ev(0, 16'h1234, 1, 0, 16'h0, 3'b001);
      ev(0, 16'h2000, 1, 0, 16'h0, 3'b010);
      chk("trigger", 32'(trig_cnt - t0), 32'h0);
      ev(0, 16'h3001, 1, 0, 16'h0, 3'b100);
      chk("trigger", 32'(trig_cnt - t0), 32'h1);
      chk("irq", irq, 1'b1);
      rd(`DACM_STATUS, 32'hf);
      repeat (2) @(posedge aclk);
      chk("irq", irq, 1'b0);
      wr(`DACM_MASK, 32'h00);
      ev(0, 16'h1234, 1, 0, 16'h0, 3'b001);
      ev(0, 16'h2000, 1, 0, 16'h0, 3'b010);
      ev(0, 16'h3001, 1, 0, 16'h0, 3'b100);
      chk("trigger", 32'(trig_cnt - t0), 32'h2);
      chk("irq", irq, 1'b0);
      wr(`DACM_SEQ, 32'h02);
      ev(0, 16'h3001, 1, 0, 16'h0, 3'b100);
      chk("trigger", 32'(trig_cnt - t0), 32'h3);
      wr(`DACM_SEQ, 32'h03);
      ev(0, 16'h3001, 1, 0, 16'h0, 3'b100);
      chk("trigger", 32'(trig_cnt - t0), 32'h3);
      rd(`DACM_SEQ, 32'h03);
      rd(`DACM_STATE, 32'h1);
      wr(`DACM_CTRL, 32'h0);
      rd(`DACM_STATE, 32'h0);
   endtask

   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_exact();
      t_size();
      t_tag();
      t_data();
      t_range();
      t_seq();
      print_verdict();
   end
endmodule

// *** verilog/dacm_cmp_if.sv ***
`timescale 1ns/100ps
`include "dacm_consts.svh"
interface dacm_cmp_if;
   logic [`DACM_CTL_W-1:0] ctl;
   logic [15:0] addr;
   logic [15:0] data;
   logic rearm;
   logic bus_valid;
   logic [15:0] bus_addr;
   logic bus_rw;
   logic bus_word;
   logic [15:0] bus_data;
   logic exec_valid;
   logic [15:0] exec_addr;
   logic hit;
   modport comp (input ctl, addr, data, rearm, bus_valid, bus_addr, bus_rw,
      bus_word, bus_data, exec_valid, exec_addr, output hit);
   modport owner (output ctl, addr, data, rearm, bus_valid, bus_addr, bus_rw,
      bus_word, bus_data, exec_valid, exec_addr, input hit);
endinterface

// *** verilog/dacm_comp.sv ***
`timescale 1ns/100ps
`include "dacm_consts.svh"
module dacm_comp #(
   parameter bit HAS_SIZE = 1'b1,
   parameter bit HAS_DATA = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   dacm_cmp_if.comp c
);
   import dacm_pkg::*;
   logic hit_q;
   logic once;
   wire tag = c.ctl[`DACM_CTL_TAG];
   wire exec_hit = c.exec_valid && (c.exec_addr == c.addr);
   wire dir_ok = !c.ctl[`DACM_CTL_DIR_EN] ||
      (c.ctl[`DACM_CTL_DIR_SEL] == c.bus_rw);
   wire size_ok = !HAS_SIZE || !c.ctl[`DACM_CTL_SIZE_EN] ||
      (c.ctl[`DACM_CTL_SIZE_SEL] == c.bus_word);
   wire data_eq = c.bus_word ? (c.bus_data == c.data) :
      (c.bus_data[7:0] == c.data[7:0]);
   wire data_ok = !HAS_DATA || !c.ctl[`DACM_CTL_DATA_EN] || once || data_eq;
   wire addr_eq = c.bus_addr == c.addr;
   wire bus_hit = c.bus_valid && addr_eq && dir_ok && size_ok && data_ok;
   wire next_hit = tag ? exec_hit : bus_hit;
   assign c.hit = hit_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hit_q <= 1'b0;
         once <= 1'b0;
      end
      else
      begin
         hit_q <= next_hit;
         once <= (once & !c.rearm) | next_hit;
      end
   end

   tag_exec_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tag && c.exec_valid && c.exec_addr == c.addr |=> c.hit)
      else $error("tagged execution did not match");
   tag_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tag && !(c.exec_valid && c.exec_addr == c.addr) |=> !c.hit)
      else $error("tagged comparator matched without execution");
   addr_exact_a: assert property (@(posedge aclk) disable iff (!aresetn)
      c.hit && !$past(tag) |->
      $past(c.bus_valid) && $past(c.bus_addr) == $past(c.addr))
      else $error("match without exact address");
   dir_qual_a: assert property (@(posedge aclk) disable iff (!aresetn)
      c.hit && !$past(tag) && $past(c.ctl[`DACM_CTL_DIR_EN]) |->
      $past(c.bus_rw) == $past(c.ctl[`DACM_CTL_DIR_SEL]))
      else $error("match with wrong direction");
   generate
      if (HAS_SIZE)
      begin : g_size
         size_qual_a: assert property (@(posedge aclk)
            disable iff (!aresetn)
            c.hit && !$past(tag) && $past(c.ctl[`DACM_CTL_SIZE_EN]) |->
            $past(c.bus_word) == $past(c.ctl[`DACM_CTL_SIZE_SEL]))
            else $error("match with wrong access size");
      end
   endgenerate
endmodule

// *** verilog/dacm_consts.svh ***
// Operation
// - only comparators A and B have size compare enable and size select
// - with tag set, match waits for the tagged instruction to execute
// - while tagging, direction, size and data qualifiers are ignored
// - with tag clear, match fires when the address is on the bus
// - once matched, a comparator no longer re-checks its data value
// - match 0, 1, 2 come from comparators A, B, C outside range mode
// - outside range mode, a match needs exact address equality
// - comparator C checks only address and direction
// - a word access at n-1 does not match a comparator holding n
// - direction enable 0 takes both; else select 0 writes, 1 reads
// - comparator B compares address, direction, access size and data value
// - size enable set matches only accesses of the selected size
// - in range mode match 1 is off and match 0 signals range entry
// - sequencer triggers after a programmed ordered run of matches
`ifndef DACM_CONSTS_SVH
`define DACM_CONSTS_SVH
`define DACM_CTRL 8'h00
`define DACM_CMP_CTL0 8'h04
`define DACM_CMP_ADDR0 8'h10
`define DACM_CMP_DATA0 8'h1c
`define DACM_SEQ 8'h24
`define DACM_STATUS 8'h28
`define DACM_MASK 8'h2c
`define DACM_STATE 8'h30
`define DACM_CTRL_ARM 0
`define DACM_CTRL_RANGE 1
`define DACM_CTL_TAG 0
`define DACM_CTL_DIR_EN 1
`define DACM_CTL_DIR_SEL 2
`define DACM_CTL_SIZE_EN 3
`define DACM_CTL_SIZE_SEL 4
`define DACM_CTL_DATA_EN 5
`define DACM_CTL_W 6
`define DACM_ST_TRIG 3
`define DACM_ST_W 4
`define DACM_RESP_OKAY 2'h0
`define DACM_RESP_SLVERR 2'h2
`endif

// *** verilog/dacm_pkg.sv ***
package dacm_pkg;
   typedef enum logic [1:0] {SQ_IDLE, SQ_STEP1, SQ_STEP2, SQ_STEP3} dacm_seq_t;
   typedef logic [15:0] dacm_addr_t;
endpackage

// *** verilog/dacm_top.sv ***
`timescale 1ns/100ps
`include "dacm_consts.svh"
module dacm_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic bus_valid,
   input wire dacm_pkg::dacm_addr_t bus_addr,
   input wire logic bus_rw,
   input wire logic bus_word,
   input wire logic [15:0] bus_data,
   input wire logic exec_valid,
   input wire dacm_pkg::dacm_addr_t exec_addr,
   output logic [2:0] match_out,
   output logic trigger,
   output logic irq
);
   import dacm_pkg::*;

   // configuration
   logic arm;
   logic range_en;
   logic [`DACM_CTL_W-1:0] cmp_ctl [3];
   logic [15:0] cmp_addr [3];
   logic [15:0] cmp_data [2];
   logic [7:0] seq_cfg;
   logic [`DACM_ST_W-1:0] status;
   logic [`DACM_ST_W-1:0] mask;
   dacm_seq_t seq;
   dacm_seq_t next_seq;
   logic in_range_q;
   logic entry_q;
   logic [2:0] rearm;

   // write channel holding
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   dacm_cmp_if cif [3] ();
   wire [2:0] hits = {cif[2].hit, cif[1].hit, cif[0].hit};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_cmp
         assign cif[gi].ctl = cmp_ctl[gi];
         assign cif[gi].addr = cmp_addr[gi];
         assign cif[gi].data = (gi < 2) ? cmp_data[gi % 2] : 16'h0000;
         assign cif[gi].rearm = rearm[gi];
         assign cif[gi].bus_valid = bus_valid;
         assign cif[gi].bus_addr = bus_addr;
         assign cif[gi].bus_rw = bus_rw;
         assign cif[gi].bus_word = bus_word;
         assign cif[gi].bus_data = bus_data;
         assign cif[gi].exec_valid = exec_valid;
         assign cif[gi].exec_addr = exec_addr;
         dacm_comp #(
            .HAS_SIZE(gi < 2),
            .HAS_DATA(gi < 2)
         ) u_comp (
            .aclk(aclk),
            .aresetn(aresetn),
            .c(cif[gi])
         );
      end
   endgenerate

   // range entry between A and B
   wire in_range = bus_valid && (bus_addr >= cmp_addr[0]) &&
      (bus_addr <= cmp_addr[1]);
   wire [2:0] m_vec = range_en ? {hits[2], 1'b0, entry_q} : hits;

   // sequencer
   wire [1:0] seq_len = (seq_cfg[7:6] == 2'h0) ? 2'h1 : seq_cfg[7:6];
   wire [1:0] step_idx = (seq == SQ_STEP2) ? 2'h1 :
      (seq == SQ_STEP3) ? 2'h2 : 2'h0;
   wire [1:0] want_ch = seq_cfg[2*step_idx +: 2];
   wire step_hit = (want_ch != 2'h3) && m_vec[want_ch];
   wire seq_done = step_hit && (step_idx + 2'h1 == seq_len);

   always_comb
   begin
      next_seq = seq;
      case (seq)
         SQ_IDLE: next_seq = arm ? SQ_STEP1 : SQ_IDLE;
         SQ_STEP1: if (step_hit) next_seq = seq_done ? SQ_STEP1 : SQ_STEP2;
         SQ_STEP2: if (step_hit) next_seq = seq_done ? SQ_STEP1 : SQ_STEP3;
         SQ_STEP3: if (step_hit) next_seq = SQ_STEP1;
         default: next_seq = SQ_IDLE;
      endcase
      if (!arm)
         next_seq = SQ_IDLE;
   end

   // bus decode
   wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire [7:0] wa = aw_addr_q;
   wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
      {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire [31:0] wd = w_data_q & wmask;
   wire wr_ctrl = wr_go && wa == `DACM_CTRL;
   wire wr_seq = wr_go && wa == `DACM_SEQ;
   wire wr_mask = wr_go && wa == `DACM_MASK;
   wire [2:0] wr_ctl;
   wire [2:0] wr_addr;
   wire [1:0] wr_data;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_dec
         assign wr_ctl[gi] = wr_go && wa == `DACM_CMP_CTL0 + 8'(4 * gi);
         assign wr_addr[gi] = wr_go && wa == `DACM_CMP_ADDR0 + 8'(4 * gi);
         if (gi < 2)
         begin : g_d
            assign wr_data[gi] = wr_go && wa == `DACM_CMP_DATA0 + 8'(4 * gi);
         end
      end
   endgenerate
   wire wr_ok = wr_ctrl | wr_seq | wr_mask | (|wr_ctl) | (|wr_addr) |
      (|wr_data) | (wa == `DACM_STATUS) | (wa == `DACM_STATE);

   wire rd_go = s_axi_arvalid && s_axi_arready;
   wire [7:0] ra = s_axi_araddr;
   wire [31:0] rd_val =
      (ra == `DACM_CTRL) ? {30'h0, range_en, arm} :
      (ra == `DACM_CMP_CTL0) ? 32'(cmp_ctl[0]) :
      (ra == `DACM_CMP_CTL0 + 8'h04) ? 32'(cmp_ctl[1]) :
      (ra == `DACM_CMP_CTL0 + 8'h08) ? 32'(cmp_ctl[2]) :
      (ra == `DACM_CMP_ADDR0) ? {16'h0, cmp_addr[0]} :
      (ra == `DACM_CMP_ADDR0 + 8'h04) ? {16'h0, cmp_addr[1]} :
      (ra == `DACM_CMP_ADDR0 + 8'h08) ? {16'h0, cmp_addr[2]} :
      (ra == `DACM_CMP_DATA0) ? {16'h0, cmp_data[0]} :
      (ra == `DACM_CMP_DATA0 + 8'h04) ? {16'h0, cmp_data[1]} :
      (ra == `DACM_SEQ) ? {24'h0, seq_cfg} :
      (ra == `DACM_STATUS) ? 32'(status) :
      (ra == `DACM_MASK) ? 32'(mask) :
      (ra == `DACM_STATE) ? {30'h0, seq} : 32'h0;
   wire rd_ok = (ra <= `DACM_STATE) && (ra[1:0] == 2'h0);
   wire rd_status = rd_go && ra == `DACM_STATUS;
   wire [`DACM_ST_W-1:0] events = {seq_done && seq != SQ_IDLE, m_vec};

   // write channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DACM_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            s_axi_awready <= 1'b0;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            s_axi_wready <= 1'b0;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `DACM_RESP_OKAY : `DACM_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `DACM_RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_arready <= 1'b0;
         s_axi_rdata <= rd_ok ? rd_val : 32'h0;
         s_axi_rresp <= rd_ok ? `DACM_RESP_OKAY : `DACM_RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // configuration registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arm <= 1'b0;
         range_en <= 1'b0;
         seq_cfg <= 8'h00;
         mask <= '0;
         rearm <= 3'h0;
         for (int i = 0; i < 3; i++)
         begin
            cmp_ctl[i] <= '0;
            cmp_addr[i] <= 16'h0000;
         end
         for (int i = 0; i < 2; i++)
            cmp_data[i] <= 16'h0000;
      end
      else
      begin
         if (wr_ctrl)
         begin
            arm <= wd[`DACM_CTRL_ARM];
            range_en <= wd[`DACM_CTRL_RANGE];
         end
         if (wr_seq)
            seq_cfg <= wd[7:0];
         if (wr_mask)
            mask <= wd[`DACM_ST_W-1:0];
         rearm <= wr_ctl | wr_addr | {1'b0, wr_data};
         for (int i = 0; i < 3; i++)
         begin
            if (wr_ctl[i])
               cmp_ctl[i] <= wd[`DACM_CTL_W-1:0];
            if (wr_addr[i])
               cmp_addr[i] <= wd[15:0];
         end
         for (int i = 0; i < 2; i++)
            if (wr_data[i])
               cmp_data[i] <= wd[15:0];
      end
   end

   // block state, status and outputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         seq <= SQ_IDLE;
         in_range_q <= 1'b0;
         entry_q <= 1'b0;
         status <= '0;
         match_out <= 3'h0;
         trigger <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         seq <= next_seq;
         if (bus_valid)
            in_range_q <= in_range;
         entry_q <= in_range && !in_range_q;
         status <= (rd_status ? '0 : status) | events;
         match_out <= m_vec;
         trigger <= seq_done && seq != SQ_IDLE;
         irq <= |(status & mask);
      end
   end

   route_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !$past(range_en) |-> match_out == $past(hits))
      else $error("match outputs not routed from comparators");
   range_m1_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(range_en) |-> !match_out[1] && match_out[0] == $past(entry_q))
      else $error("range mode routing wrong");
   trig_seq_a: assert property (@(posedge aclk) disable iff (!aresetn)
      trigger |-> $past(seq) != SQ_IDLE && $past(step_hit) &&
      $past(step_idx) + 2'h1 == $past(seq_len))
      else $error("trigger without completed sequence");
   reset_a: assert property (@(posedge aclk)
      !aresetn |=> seq == SQ_IDLE && match_out == 3'h0 && !trigger)
      else $error("reset left match state");
   irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 irq == |($past(status) & $past(mask)))
      else $error("interrupt level mismatch");
   three_step_c: cover property (@(posedge aclk) disable iff (!aresetn)
      seq == SQ_STEP3 ##[1:50] trigger);
   range_entry_c: cover property (@(posedge aclk) disable iff (!aresetn)
      range_en && entry_q);
   tagged_c: cover property (@(posedge aclk) disable iff (!aresetn)
      cmp_ctl[0][`DACM_CTL_TAG] && hits[0]);
endmodule
